// file: inc/duc_pkg.sv
`default_nettype none
package duc_pkg;
	// ************************************
	// Timing
	// ************************************
	localparam int CLK_PS = 8000;
	localparam int STAGE_NS = 600;
	localparam int TAIL_NS = 300;
	localparam int ABSEL_NS = 500;
	localparam int RESET_US = 300;
	localparam logic [15:0] STAGE_CYC = 16'((STAGE_NS * 1000) / CLK_PS);
	localparam logic [15:0] TAIL_CYC = 16'((TAIL_NS * 1000) / CLK_PS);
	localparam logic [15:0] ABSEL_CYC = 16'((ABSEL_NS * 1000) / CLK_PS);
	localparam logic [15:0] RESET_CYC = 16'((RESET_US * 1000000) / CLK_PS);
	// ************************************
	// Register map
	// ************************************
	localparam logic [7:0] ADDR_DATA = 8'h00;
	localparam logic [7:0] ADDR_ABSEL0 = 8'h04;
	localparam logic [7:0] ADDR_ABSEL3 = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam logic [7:0] ADDR_RBSEL = 8'h18;
	localparam logic [7:0] ADDR_RBDAC = 8'h1C;
	localparam int ST_BIT_OWN = 0;
	localparam int ST_BIT_LINE = 1;
	localparam int ST_BIT_RESET = 2;
	localparam int ST_BIT_PEND = 3;
	localparam int ST_BIT_CLR = 4;
	// ************************************
	// Defaults and encodings
	// ************************************
	localparam int NUM_CH = 32;
	localparam logic [15:0] DEF_INPUT = 16'h5554;
	localparam logic [15:0] DEF_GAIN = 16'hFFFF;
	localparam logic [15:0] DEF_OFFSET = 16'h8000;
	localparam logic [15:0] DEF_DAC = 16'h5554;
	localparam logic [18:0] MID_CODE = 19'h0_8000;
	localparam logic [2:0] MODE_ONE = 3'h0;
	localparam logic [2:0] MODE_GROUP = 3'h1;
	localparam logic [2:0] MODE_G03 = 3'h2;
	localparam logic [2:0] MODE_G13 = 3'h3;
	localparam logic [2:0] MODE_ALL = 3'h4;
	localparam logic [1:0] TGT_A = 2'h0;
	localparam logic [1:0] TGT_B = 2'h1;
	localparam logic [1:0] TGT_GAIN = 2'h2;
	localparam logic [1:0] TGT_OFFS = 2'h3;
	typedef struct packed {
		logic [2:0] rsv_hi;
		logic [2:0] chan;
		logic [1:0] group;
		logic rsv_mid;
		logic [2:0] mode;
		logic [1:0] rsv_lo;
		logic [1:0] target;
		logic [15:0] value;
	} duc_wr_type;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CALC = 2'b01,
		ST_TAIL = 2'b11,
		ST_RESET = 2'b10
	} duc_state_type;
endpackage
`default_nettype wire

// file: hdl/duc_control.sv
// Local design decisions: the APB interface to the registers and the address map.
`default_nettype none
module duc_control #(
	parameter logic [15:0] RESET_CYCLES = duc_pkg::RESET_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic device_reset_n,
	input wire logic zero_outputs_n,
	input wire logic load_outputs_n,
	input wire logic busy_line_in,
	output logic busy_line_out,
	output logic busy_line_oe,
	output logic outputs_grounded,
	output logic output_update
);
	import duc_pkg::*;

	// ************************************
	// Helpers
	// ************************************
	function automatic logic [31:0] chan_mask(input duc_wr_type w);
		logic [31:0] m;
		m = 32'h0000_0000;
		unique case (w.mode)
			MODE_ONE: m[{w.group, w.chan}] = 1'b1;
			MODE_GROUP: m = 32'h0000_00FF << {w.group, 3'b000};
			MODE_G03: m = 32'h0101_0101 << w.chan;
			MODE_G13: m = 32'h0101_0100 << w.chan;
			MODE_ALL: m = 32'hFFFF_FFFF;
			default: m = 32'h0000_0000;
		endcase
		return m;
	endfunction

	function automatic logic [4:0] first_set(input logic [31:0] v);
		logic [4:0] r;
		r = 5'h00;
		for (int i = NUM_CH - 1; i >= 0; i--)
			if (v[i])
				r = 5'(i);
		return r;
	endfunction

	// Clamped x*(g+1)/2^16 + c - mid; negative clamps to zero
	function automatic logic [15:0] calc_fn(input logic [15:0] x, g, c);
		logic [32:0] prod;
		logic [18:0] sum;
		prod = 33'(x) * 33'(g) + 33'(x);
		sum = 19'(prod[32:16]) + 19'(c) - MID_CODE;
		if (sum[18])
			return 16'h0000;
		else if (sum[17:16] != 2'b00)
			return 16'hFFFF;
		return sum[15:0];
	endfunction

	function automatic logic addr_ok(input logic [7:0] a);
		return a[1:0] == 2'b00 && a <= ADDR_RBDAC;
	endfunction

	// ************************************
	// Pin synchronisers
	// ************************************
	logic [3:0] sync1, sync2, sync3;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			// Pins start at idle level; reset bit low so release starts the sequence
			sync1 <= 4'hE;
			sync2 <= 4'hE;
			sync3 <= 4'hE;
		end
		else
		begin
			sync1 <= {busy_line_in, load_outputs_n, zero_outputs_n, device_reset_n};
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	logic rst_rise, clr_low, load_outputs_n_fall, load_outputs_n_low, line_high;
	assign rst_rise = sync2[0] & ~sync3[0];
	assign clr_low = ~sync2[1];
	assign load_outputs_n_fall = ~sync2[2] & sync3[2];
	assign load_outputs_n_low = ~sync2[2];
	assign line_high = sync2[3];

	// ************************************
	// APB slave, one wait state
	// ************************************
	duc_state_type state;
	logic [15:0] cnt;
	logic [4:0] cur_ch;
	logic [15:0] input_a [0:NUM_CH-1];
	logic [15:0] input_b [0:NUM_CH-1];
	logic [15:0] gain [0:NUM_CH-1];
	logic [15:0] offset [0:NUM_CH-1];
	logic [15:0] calc_a [0:NUM_CH-1];
	logic [15:0] calc_b [0:NUM_CH-1];
	logic [15:0] dac [0:NUM_CH-1];
	logic [31:0] dirty_a, dirty_b, written_a, written_b, absel, pend_next;
	logic [15:0] ab_cnt;
	logic [4:0] rb_sel;
	logic pend, free_q, apply, bus_free, busy_rise, resetting;
	logic wr_en, data_wr, absel_wr, calc_done, any_dirty;
	logic [31:0] wr_mask, ab_mask, rdata;
	logic [1:0] ab_grp;
	duc_wr_type wr;

	assign resetting = state == ST_RESET;
	assign wr_en = psel & penable & pready & pwrite;
	assign wr = duc_wr_type'(pwdata);
	assign wr_mask = chan_mask(wr);
	// Data and select writes during the reset sequence are dropped, not queued
	assign data_wr = wr_en & (paddr == ADDR_DATA) & ~resetting;
	assign absel_wr = wr_en & (paddr >= ADDR_ABSEL0) & (paddr <= ADDR_ABSEL3)
		& (paddr[1:0] == 2'b00) & ~resetting;
	assign ab_grp = 2'(paddr[4:2] - 3'h1);
	assign ab_mask = 32'h0000_00FF << {ab_grp, 3'b000};

	always_comb
	begin
		rdata = 32'h0000_0000;
		if (paddr >= ADDR_ABSEL0 && paddr <= ADDR_ABSEL3)
			rdata[7:0] = absel[{ab_grp, 3'b000} +: 8];
		else if (paddr == ADDR_STATUS)
		begin
			rdata[ST_BIT_OWN] = busy_line_oe;
			rdata[ST_BIT_LINE] = ~line_high;
			rdata[ST_BIT_RESET] = resetting;
			rdata[ST_BIT_PEND] = pend;
			rdata[ST_BIT_CLR] = outputs_grounded;
		end
		else if (paddr == ADDR_RBSEL)
			rdata[4:0] = rb_sel;
		else if (paddr == ADDR_RBDAC)
			rdata[15:0] = dac[rb_sel];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			rb_sel <= 5'h00;
		end
		else
		begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~addr_ok(paddr);
			prdata <= (psel & penable & ~pready) ? rdata : 32'h0000_0000;
			if (wr_en && paddr == ADDR_RBSEL)
				rb_sel <= pwdata[4:0];
		end
	end

	// ************************************
	// Input, gain and offset registers
	// ************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < NUM_CH; i++)
			begin
				input_a[i] <= DEF_INPUT;
				input_b[i] <= DEF_INPUT;
				gain[i] <= DEF_GAIN;
				offset[i] <= DEF_OFFSET;
			end
		end
		else if (rst_rise)
		begin
			for (int i = 0; i < NUM_CH; i++)
			begin
				input_a[i] <= DEF_INPUT;
				input_b[i] <= DEF_INPUT;
				gain[i] <= DEF_GAIN;
				offset[i] <= DEF_OFFSET;
			end
		end
		else if (data_wr)
		begin
			for (int i = 0; i < NUM_CH; i++)
				if (wr_mask[i])
					unique case (wr.target)
						TGT_A: input_a[i] <= wr.value;
						TGT_B: input_b[i] <= wr.value;
						TGT_GAIN: gain[i] <= wr.value;
						TGT_OFFS: offset[i] <= wr.value;
					endcase
		end
	end

	// A/B select, one byte per group of eight
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			absel <= 32'h0000_0000;
			ab_cnt <= 16'h0000;
		end
		else if (absel_wr)
		begin
			absel[{ab_grp, 3'b000} +: 8] <= pwdata[7:0];
			ab_cnt <= ABSEL_CYC;
		end
		else if (ab_cnt != 16'h0000)
			ab_cnt <= ab_cnt - 16'h0001;
	end

	// ************************************
	// Recalculation engine
	// ************************************
	assign any_dirty = |(dirty_a | dirty_b);
	assign calc_done = (state == ST_CALC) && (cnt == STAGE_CYC - 16'h0001);
	assign pend_next = (dirty_a | dirty_b) & ~(32'h0000_0001 << cur_ch);

	// Later writes only mark channels; new marks win over completion
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dirty_a <= 32'h0000_0000;
			dirty_b <= 32'h0000_0000;
		end
		else if (rst_rise)
		begin
			dirty_a <= 32'h0000_0000;
			dirty_b <= 32'h0000_0000;
		end
		else
		begin
			dirty_a <= (dirty_a & ~(calc_done ? 32'h0000_0001 << cur_ch : 32'h0000_0000))
				| (data_wr && wr.target != TGT_B ? wr_mask : 32'h0000_0000);
			dirty_b <= (dirty_b & ~(calc_done ? 32'h0000_0001 << cur_ch : 32'h0000_0000))
				| (data_wr && wr.target != TGT_A ? wr_mask : 32'h0000_0000);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state <= ST_IDLE;
			cnt <= 16'h0000;
			cur_ch <= 5'h00;
		end
		else if (rst_rise)
		begin
			state <= ST_RESET;
			cnt <= 16'h0000;
		end
		else
		begin
			unique case (state)
				ST_IDLE:
					if (any_dirty)
					begin
						state <= ST_CALC;
						cur_ch <= first_set(dirty_a | dirty_b);
						cnt <= 16'h0000;
					end
				ST_CALC:
					// Two multipliers, A and B side by side: one channel per stage slot
					if (calc_done)
					begin
						cnt <= 16'h0000;
						if (|pend_next)
							cur_ch <= first_set(pend_next);
						else
							state <= ST_TAIL;
					end
					else
						cnt <= cnt + 16'h0001;
				ST_TAIL:
					// One stage plus the tail, less the idle-to-calc cycle, keeps pulse in bound
					if (any_dirty)
					begin
						state <= ST_CALC;
						cur_ch <= first_set(dirty_a | dirty_b);
						cnt <= 16'h0000;
					end
					else if (cnt == STAGE_CYC + TAIL_CYC - 16'h0002)
						state <= ST_IDLE;
					else
						cnt <= cnt + 16'h0001;
				ST_RESET:
					if (cnt == RESET_CYCLES - 16'h0001)
						state <= ST_IDLE;
					else
						cnt <= cnt + 16'h0001;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < NUM_CH; i++)
			begin
				calc_a[i] <= DEF_DAC;
				calc_b[i] <= DEF_DAC;
			end
		end
		else if (rst_rise)
		begin
			for (int i = 0; i < NUM_CH; i++)
			begin
				calc_a[i] <= DEF_DAC;
				calc_b[i] <= DEF_DAC;
			end
		end
		else if (calc_done)
		begin
			if (dirty_a[cur_ch])
				calc_a[cur_ch] <= calc_fn(input_a[cur_ch], gain[cur_ch], offset[cur_ch]);
			if (dirty_b[cur_ch])
				calc_b[cur_ch] <= calc_fn(input_b[cur_ch], gain[cur_ch], offset[cur_ch]);
		end
	end

	// Changed-since-load flags; a fresh result wins over the load clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			written_a <= 32'h0000_0000;
			written_b <= 32'h0000_0000;
		end
		else if (rst_rise)
		begin
			written_a <= 32'h0000_0000;
			written_b <= 32'h0000_0000;
		end
		else
		begin
			written_a <= (written_a & ~(apply ? ~absel : 32'h0000_0000))
				| (calc_done && dirty_a[cur_ch] ? 32'h0000_0001 << cur_ch : 32'h0000_0000)
				| (absel_wr ? ab_mask : 32'h0000_0000);
			written_b <= (written_b & ~(apply ? absel : 32'h0000_0000))
				| (calc_done && dirty_b[cur_ch] ? 32'h0000_0001 << cur_ch : 32'h0000_0000)
				| (absel_wr ? ab_mask : 32'h0000_0000);
		end
	end

	// ************************************
	// Busy line and load handling
	// ************************************
	// Own drive counted directly so the sync lag cannot let a load slip through
	assign bus_free = line_high & ~busy_line_oe;
	assign busy_rise = bus_free & ~free_q;
	assign apply = ~clr_low & bus_free & ~resetting
		& (pend | load_outputs_n_fall | (load_outputs_n_low & busy_rise));

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			busy_line_out <= 1'b0;
			busy_line_oe <= 1'b0;
			free_q <= 1'b0;
		end
		else
		begin
			busy_line_out <= 1'b0;
			busy_line_oe <= (state != ST_IDLE) | any_dirty | (ab_cnt != 16'h0000);
			free_q <= bus_free;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pend <= 1'b0;
		else if (rst_rise)
			pend <= 1'b0;
		else
			pend <= (pend & ~apply) | (load_outputs_n_fall & ~bus_free & ~clr_low);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < NUM_CH; i++)
				dac[i] <= DEF_DAC;
			output_update <= 1'b0;
			outputs_grounded <= 1'b0;
		end
		else
		begin
			output_update <= apply;
			// Clear only gates the output stage; stored codes stay
			outputs_grounded <= clr_low;
			for (int i = 0; i < NUM_CH; i++)
				if (rst_rise)
					dac[i] <= DEF_DAC;
				else if (apply && absel[i] && written_b[i])
					dac[i] <= calc_b[i];
				else if (apply && !absel[i] && written_a[i])
					dac[i] <= calc_a[i];
		end
	end

	// ************************************
	// Checks
	// ************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	AST_RESET_START: assert property (rst_rise |=> state == ST_RESET)
		else $error("reset edge did not start sequence");
	AST_RESET_HOLD: assert property ($rose(resetting) |-> resetting [*8])
		else $error("reset sequence ended early");
	AST_RESET_GND: assert property (resetting |-> dac[0] == DEF_DAC && !written_a[0])
		else $error("output not at ground level after reset");
	AST_LOW_NOP: assert property (!sync2[0] && state == ST_IDLE && !any_dirty |=> !resetting)
		else $error("low reset level changed operation");
	AST_CLR_IGNORE: assert property (clr_low |-> !apply)
		else $error("load taken while clear low");
	AST_CLR_KEEP: assert property (clr_low && !resetting && !rst_rise |=> $stable(dac[0]))
		else $error("clear altered a dac register");
	AST_BUSY_WR: assert property (data_wr |-> ##2 busy_line_oe)
		else $error("busy not driven after write");
	AST_NO_UPD_BUSY: assert property (!line_high |-> !apply)
		else $error("update while busy line low");
	AST_PEND: assert property (load_outputs_n_fall && !bus_free && !clr_low && !rst_rise |=> pend)
		else $error("load during busy not stored");
	AST_ONE_SHOT: assert property (apply && !load_outputs_n_fall |=> !pend)
		else $error("stored load not discarded");
	AST_ABSEL: assert property (absel_wr |-> ##2 busy_line_oe [*8])
		else $error("select write did not hold busy");
	AST_TAIL: assert property (calc_done && !(|pend_next) && !rst_rise |=> state == ST_TAIL)
		else $error("tail stage skipped");

	COV_APPLY: cover property (apply);
	COV_STORED: cover property (load_outputs_n_fall && !bus_free ##[1:400] apply);
	COV_DONE: cover property (state == ST_TAIL ##1 state == ST_IDLE);
	COV_CLR: cover property (clr_low && load_outputs_n_fall);
endmodule
`default_nettype wire

// file: verification/duc_host_model.sv
`default_nettype none
// ********
// Host pins
// ********
module duc_host_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic reset_req,
	input wire logic reset_hold,
	input wire logic load_req,
	input wire logic load_hold,
	input wire logic clear_req,
	input wire logic other_busy,
	input wire logic busy_oe,
	input wire logic busy_out,
	output logic device_reset_n,
	output logic zero_outputs_n,
	output logic load_outputs_n,
	output logic busy_line
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] rst_cnt;
	logic [2:0] ld_cnt;
	// Five cycles low, well above the minimum width
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rst_cnt <= 3'h0;
		else if (reset_req)
			rst_cnt <= 3'h5;
		else if (rst_cnt != 3'h0)
			rst_cnt <= rst_cnt - 3'h1;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			device_reset_n <= 1'b1;
		else
			device_reset_n <= !(reset_hold || reset_req || rst_cnt > 3'h1);
	end
	// Strobe long enough to pass the pin synchronizer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ld_cnt <= 3'h0;
		else if (load_req)
			ld_cnt <= 3'h5;
		else if (ld_cnt != 3'h0)
			ld_cnt <= ld_cnt - 3'h1;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			load_outputs_n <= 1'b1;
			zero_outputs_n <= 1'b1;
		end
		else
		begin
			load_outputs_n <= !(load_hold || load_req || ld_cnt > 3'h1);
			zero_outputs_n <= !clear_req;
		end
	end
	// Pull-up; a device pulls low only with enable set and data zero
	assign busy_line = !((busy_oe && !busy_out) || other_busy);
endmodule
`default_nettype wire

// file: verification/test_duc_control.sv
`default_nettype none
module test_duc_control;
	timeunit 1ns;
	timeprecision 1ps;
	import duc_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic device_reset_n, zero_outputs_n, load_outputs_n, busy_line;
	logic busy_line_oe, busy_line_out, outputs_grounded, output_update;
	logic reset_req, reset_hold, load_req, load_hold, clear_req, other_busy;
	logic [2:0] hist;
	int err_total, comparisons, n, c0;
	int upd_cnt = 0;
	int busy_err = 0;
	logic [31:0] r;
	logic e;
	logic [2:0] modes [5] = '{MODE_ONE, MODE_GROUP, MODE_G03, MODE_G13, MODE_ALL};
	int cnts [5] = '{1, 8, 4, 3, 32};
	always #4 pclk = ~pclk;
	duc_control #(.RESET_CYCLES(16'h0014)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .device_reset_n(device_reset_n),
		.zero_outputs_n(zero_outputs_n), .load_outputs_n(load_outputs_n),
		.busy_line_in(busy_line), .busy_line_out(busy_line_out), .busy_line_oe(busy_line_oe),
		.outputs_grounded(outputs_grounded), .output_update(output_update));
	duc_host_model host (.pclk(pclk), .presetn(presetn), .reset_req(reset_req),
		.reset_hold(reset_hold), .load_req(load_req), .load_hold(load_hold),
		.clear_req(clear_req), .other_busy(other_busy), .busy_oe(busy_line_oe),
		.busy_out(busy_line_out), .device_reset_n(device_reset_n),
		.zero_outputs_n(zero_outputs_n),
		.load_outputs_n(load_outputs_n), .busy_line(busy_line));
	// ********
	// Tasks
	// ********
	task automatic conclude();
		err_total += busy_err;
		$display("TB: checks %0d errors %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic hang();
		err_total++;
		$display("wrong value at %0t: wait timed out", $time);
		conclude();
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_true(input logic ok);
		chk({31'h0000_0000, ok}, 32'h0000_0001);
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rv, output logic ev);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1)
			hang();
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rv;
		logic ev;
		apb(1'b1, a, d, rv, ev);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] rv);
		logic ev;
		apb(1'b0, a, 32'h0000_0000, rv, ev);
	endtask
	task automatic chk_dac(input logic [4:0] ch, input logic [15:0] exp);
		logic [31:0] rv;
		wr(ADDR_RBSEL, {27'h000_0000, ch});
		rd(ADDR_RBDAC, rv);
		chk(rv, {16'h0000, exp});
	endtask
	task automatic chk_bit(input int b, input logic exp);
		logic [31:0] rv;
		rd(ADDR_STATUS, rv);
		chk({31'h0000_0000, rv[b]}, {31'h0000_0000, exp});
	endtask
	function automatic logic [31:0] mk(input logic [2:0] m, input logic [4:0] ch,
		input logic [1:0] t, input logic [15:0] v);
		duc_wr_type w;
		w = '0;
		w.mode = m;
		w.group = ch[4:3];
		w.chan = ch[2:0];
		w.target = t;
		w.value = v;
		return w;
	endfunction
	task automatic busy_len(output int len);
		int k;
		len = 0;
		k = 0;
		while (k < 3000 && !(len > 0 && busy_line_oe !== 1'b1))
		begin
			@(posedge pclk);
			k++;
			if (busy_line_oe === 1'b1)
				len++;
		end
		if (k >= 3000)
			hang();
	endtask
	task automatic pulse_load();
		load_req <= 1'b1;
		@(posedge pclk);
		load_req <= 1'b0;
		repeat (12) @(posedge pclk);
	endtask
	task automatic wait_seq();
		logic [31:0] rv;
		int k;
		rv = 32'hFFFF_FFFF;
		k = 0;
		repeat (5) @(posedge pclk);
		while (rv[ST_BIT_RESET] !== 1'b0 && k < 100)
		begin
			rd(ADDR_STATUS, rv);
			k++;
		end
		if (k >= 100)
			hang();
	endtask
	// No update may land while the shared line has been low for a while
	always @(posedge pclk)
	begin
		hist <= {hist[1:0], busy_line};
		if (output_update === 1'b1)
			upd_cnt++;
		if (output_update === 1'b1 && hist === 3'b000)
		begin
			busy_err++;
			$display("wrong value at %0t: update while busy", $time);
		end
	end
	// ********
	// Sequence
	// ********
	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		{reset_req, reset_hold, load_req, load_hold, clear_req, other_busy} = 6'h00;
		err_total = 0;
		comparisons = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		wait_seq();
		chk_dac(5'd0, DEF_DAC);
		chk_true(outputs_grounded === 1'b0);
		apb(1'b0, 8'h20, 32'h0000_0000, r, e);
		chk_true(e === 1'b1);
		// Load falls during busy, applied once afterwards
		c0 = upd_cnt;
		wr(ADDR_DATA, mk(MODE_ONE, 5'd5, TGT_A, 16'h1234));
		repeat (4) @(posedge pclk);
		pulse_load();
		busy_len(n);
		chk_true(n <= 2 * STAGE_CYC + TAIL_CYC);
		repeat (12) @(posedge pclk);
		chk(upd_cnt - c0, 32'h0000_0001);
		chk_bit(ST_BIT_PEND, 1'b0);
		chk_dac(5'd5, 16'h1234);
		// Another device keeps the line low
		other_busy <= 1'b1;
		wr(ADDR_DATA, mk(MODE_ONE, 5'd6, TGT_A, 16'h2222));
		busy_len(n);
		pulse_load();
		chk_dac(5'd6, DEF_DAC);
		other_busy <= 1'b0;
		repeat (10) @(posedge pclk);
		chk_dac(5'd6, 16'h2222);
		// Select A or B per channel
		wr(ADDR_DATA, mk(MODE_ONE, 5'd8, TGT_A, 16'h1111));
		busy_len(n);
		wr(ADDR_DATA, mk(MODE_ONE, 5'd8, TGT_B, 16'h3333));
		busy_len(n);
		wr(ADDR_ABSEL0 + 8'h04, 32'h0000_0001);
		busy_len(n);
		chk_true(n >= 60 && n <= 66);
		pulse_load();
		chk_dac(5'd8, 16'h3333);
		rd(ADDR_ABSEL0 + 8'h04, r);
		chk(r, 32'h0000_0001);
		wr(ADDR_ABSEL0 + 8'h04, 32'h0000_0000);
		busy_len(n);
		pulse_load();
		chk_dac(5'd8, 16'h1111);
		// Load held low
		load_hold <= 1'b1;
		wr(ADDR_DATA, mk(MODE_ONE, 5'd9, TGT_A, 16'h4444));
		busy_len(n);
		repeat (10) @(posedge pclk);
		chk_dac(5'd9, 16'h4444);
		load_hold <= 1'b0;
		// Clear held while the offset changes
		clear_req <= 1'b1;
		repeat (6) @(posedge pclk);
		chk_true(outputs_grounded === 1'b1);
		wr(ADDR_DATA, mk(MODE_ONE, 5'd10, TGT_OFFS, 16'h8100));
		busy_len(n);
		pulse_load();
		chk_dac(5'd10, DEF_DAC);
		clear_req <= 1'b0;
		repeat (6) @(posedge pclk);
		chk_true(outputs_grounded === 1'b0);
		pulse_load();
		chk_dac(5'd10, 16'h5654);
		// Addressing modes in turn, each checked on channel 11
		for (int i = 0; i < 5; i++)
		begin
			wr(ADDR_DATA, mk(modes[i], 5'd11, TGT_A, 16'(16'h1000 * (i + 1))));
			busy_len(n);
			chk_true(n <= (cnts[i] + 1) * STAGE_CYC + TAIL_CYC);
			chk_true(n >= cnts[i] * STAGE_CYC);
			pulse_load();
			chk_dac(5'd11, 16'(16'h1000 * (i + 1)));
		end
		chk_dac(5'd31, 16'h5000);
		// Reset acts on the rising edge only
		reset_hold <= 1'b1;
		repeat (30) @(posedge pclk);
		chk_bit(ST_BIT_RESET, 1'b0);
		chk_dac(5'd11, 16'h5000);
		reset_hold <= 1'b0;
		repeat (4) @(posedge pclk);
		chk_bit(ST_BIT_RESET, 1'b1);
		wr(ADDR_DATA, mk(MODE_ONE, 5'd0, TGT_A, 16'h7777));
		wait_seq();
		pulse_load();
		chk_dac(5'd0, DEF_DAC);
		chk_dac(5'd11, DEF_DAC);
		chk_true(outputs_grounded === 1'b0);
		// Short host pulse on the device reset pin
		wr(ADDR_DATA, mk(MODE_ONE, 5'd12, TGT_A, 16'h6666));
		busy_len(n);
		pulse_load();
		chk_dac(5'd12, 16'h6666);
		reset_req <= 1'b1;
		@(posedge pclk);
		reset_req <= 1'b0;
		repeat (10) @(posedge pclk);
		chk_bit(ST_BIT_RESET, 1'b1);
		wait_seq();
		chk_dac(5'd12, DEF_DAC);
		conclude();
	end
endmodule
`default_nettype wire
